/* verilog/lqsb_defines.svh */
// constants for the limit and questionable status bank
// assumes inclusion by bare name from package and design
`ifndef LQSB_DEFINES_SVH
`define LQSB_DEFINES_SVH
`define LQSB_REG_W 16
`define LQSB_NWIN 8
`define LQSB_NSENS 4
`define LQSB_ERR_W 16
`define LQSB_ERR_CORRUPT 16'hFF1A
`define LQSB_ERR_QUEST 16'hFF19
`define LQSB_GRP_LOW 2'h0
`define LQSB_GRP_UPP 2'h1
`define LQSB_GRP_PWR 2'h2
`define LQSB_GRP_WIN 2'h3
`define LQSB_PART_COND 3'h0
`define LQSB_PART_EVENT 3'h1
`define LQSB_PART_PTR 3'h2
`define LQSB_PART_NTR 3'h3
`define LQSB_PART_ENAB 3'h4
`define LQSB_WIN_LSB 1
`define LQSB_PZERO_LSB 5
`define LQSB_USED_MASK 16'h01FE
`define LQSB_PTR_RST 16'h7FFF
`define LQSB_NTR_RST 16'h0000
`define LQSB_ENAB_RST 16'h0000
`define LQSB_OPER_LOW_BIT 11
`define LQSB_OPER_UPP_BIT 12
`endif

/* verilog/lqsb_pkg.sv */
// types for the limit and questionable status bank
// assumes lqsb_defines.svh on the include path
`include "lqsb_defines.svh"
package lqsb_pkg;
  typedef logic [`LQSB_REG_W-1:0] lqsb_word_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] group;
    logic [2:0] part;
    lqsb_word_t data;
  } lqsb_req_t;
  typedef struct packed {
    logic valid;
    lqsb_word_t data;
  } lqsb_rsp_t;
endpackage

/* verilog/lqsb_bank.sv */
// four status groups: lower limit, upper limit, power and window questionable
// assumes synchronous inputs, one query port, one clock with clock enable
//
// What this block does
// R01 - lower condition bit: value below lower limit
// R02 - lower event latches filtered drop below limit
// R03 - lower check enable sets rising-edge filters
// R04 - lower group uses bits 1..8 only
// R05 - upper condition bit: value above upper limit
// R06 - upper event latches filtered limit exceedances
// R07 - upper check enable sets rising-edge filters
// R08 - upper group uses bits 1..8 only
// R09 - bit 15 always reads zero
// R10 - power bits 1..4 flag corrupt sensor data
// R11 - power bits 5..8 flag zeroing needed
// R12 - corrupt bit set on error -230/-231
// R13 - power condition shows current questionable state
// R14 - window bits 1..8 flag corrupt results
// R15 - window bit set on error -231
// R16 - lower summary drives operation bit 11
// R17 - upper summary drives operation bit 12
// R18 - negative filter records one-to-zero changes
// R19 - each query returns one bit pattern
// R20 - event read clears, condition read keeps
// R21 - event set per positive/negative filter bit
`include "lqsb_defines.svh"
module lqsb_bank
  import lqsb_pkg::*;
#(
  parameter int NWIN = `LQSB_NWIN,
  parameter int NSENS = `LQSB_NSENS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [NWIN-1:0] win_below_low,
  input wire logic [NWIN-1:0] win_above_upp,
  input wire logic lower_limit_check_enable,
  input wire logic upper_limit_check_enable,
  input wire logic [NSENS-1:0] sens_err_valid,
  input wire logic [NSENS*`LQSB_ERR_W-1:0] sens_err_code,
  input wire logic [NSENS-1:0] sens_err_clear,
  input wire logic [NSENS-1:0] sens_zero_stale,
  input wire logic [NWIN-1:0] win_err_valid,
  input wire logic [NWIN*`LQSB_ERR_W-1:0] win_err_code,
  input wire logic [NWIN-1:0] win_err_clear,
  input wire lqsb_req_t req,
  output lqsb_rsp_t rsp,
  output logic oper_low_sum,
  output logic oper_upp_sum
);

  // condition words, built from the live inputs and the registered corrupt flags; unused bits and bit 15 zero
  lqsb_word_t cond_nxt [4];
  logic [NSENS-1:0] sens_corrupt_r;
  logic [NWIN-1:0] win_corrupt_r;
  logic [NSENS-1:0] sens_hit;
  logic [NWIN-1:0] win_hit;

  function automatic lqsb_word_t place_win(input logic [NWIN-1:0] v);
    lqsb_word_t w;
    w = '0;
    w[`LQSB_WIN_LSB +: NWIN] = v;
    return w & `LQSB_USED_MASK;
  endfunction

  // error code decode per sensor and per window
  always_comb begin
    for (int i = 0; i < NSENS; i++) begin
      sens_hit[i] = sens_err_valid[i] &&
        (sens_err_code[i*`LQSB_ERR_W +: `LQSB_ERR_W] == `LQSB_ERR_CORRUPT ||
         sens_err_code[i*`LQSB_ERR_W +: `LQSB_ERR_W] == `LQSB_ERR_QUEST); // see R12
    end
    for (int j = 0; j < NWIN; j++) begin
      win_hit[j] = win_err_valid[j] &&
        win_err_code[j*`LQSB_ERR_W +: `LQSB_ERR_W] == `LQSB_ERR_QUEST; // see R15
    end
  end

  // corrupt flags persist until the error source clears; set wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sens_corrupt_r <= '0;
      win_corrupt_r <= '0;
    end else if (clk_en) begin
      sens_corrupt_r <= sens_hit | (sens_corrupt_r & ~sens_err_clear); // see R12
      win_corrupt_r <= win_hit | (win_corrupt_r & ~win_err_clear); // see R15
    end
  end

  // condition words for each group
  always_comb begin
    cond_nxt[`LQSB_GRP_LOW] = place_win(win_below_low); // see R01 see R04 see R09
    cond_nxt[`LQSB_GRP_UPP] = place_win(win_above_upp); // see R05 see R08
    cond_nxt[`LQSB_GRP_PWR] = '0;
    cond_nxt[`LQSB_GRP_PWR][`LQSB_WIN_LSB +: NSENS] = sens_corrupt_r; // see R10 see R13
    cond_nxt[`LQSB_GRP_PWR][`LQSB_PZERO_LSB +: NSENS] = sens_zero_stale; // see R11
    cond_nxt[`LQSB_GRP_WIN] = place_win(win_corrupt_r); // see R14
  end

  lqsb_word_t cond_r [4];
  lqsb_word_t event_r [4];
  lqsb_word_t ptr_r [4];
  lqsb_word_t ntr_r [4];
  lqsb_word_t enab_r [4];
  lqsb_word_t rise [4];
  lqsb_word_t fall [4];
  lqsb_word_t hit [4];
  lqsb_word_t clr [4];
  lqsb_word_t rd_mux;

  wire q_rd = req.valid && !req.write;
  wire q_wr = req.valid && req.write;
  wire [1:0] g = req.group;

  // transition detect and read-clear per group
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      rise[k] = cond_nxt[k] & ~cond_r[k];
      fall[k] = ~cond_nxt[k] & cond_r[k];
      hit[k] = ((rise[k] & ptr_r[k]) | (fall[k] & ntr_r[k])) & `LQSB_USED_MASK; // see R21 see R18
      clr[k] = (q_rd && g == k[1:0] && req.part == `LQSB_PART_EVENT) ? '1 : '0; // see R20
    end
  end

  // read selection of one register part
  always_comb begin
    unique case (req.part)
      `LQSB_PART_COND: rd_mux = cond_r[g];
      `LQSB_PART_EVENT: rd_mux = event_r[g];
      `LQSB_PART_PTR: rd_mux = ptr_r[g];
      `LQSB_PART_NTR: rd_mux = ntr_r[g];
      `LQSB_PART_ENAB: rd_mux = enab_r[g];
      default: rd_mux = '0;
    endcase
  end

  // register state; new events win over a read clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < 4; k++) begin
        cond_r[k] <= '0;
        event_r[k] <= '0;
        ptr_r[k] <= `LQSB_PTR_RST & `LQSB_USED_MASK;
        ntr_r[k] <= `LQSB_NTR_RST;
        enab_r[k] <= `LQSB_ENAB_RST;
      end
    end else if (clk_en) begin
      for (int k = 0; k < 4; k++) begin
        cond_r[k] <= cond_nxt[k];
        event_r[k] <= hit[k] | (event_r[k] & ~clr[k]); // see R02 see R06 see R20
        if (q_wr && g == k[1:0]) begin
          if (req.part == `LQSB_PART_PTR) ptr_r[k] <= req.data & `LQSB_USED_MASK; // see R09
          if (req.part == `LQSB_PART_NTR) ntr_r[k] <= req.data & `LQSB_USED_MASK;
          if (req.part == `LQSB_PART_ENAB) enab_r[k] <= req.data & `LQSB_USED_MASK;
        end
      end
      if (lower_limit_check_enable) begin
        ptr_r[`LQSB_GRP_LOW] <= `LQSB_USED_MASK; // see R03
        ntr_r[`LQSB_GRP_LOW] <= '0;
      end
      if (upper_limit_check_enable) begin
        ptr_r[`LQSB_GRP_UPP] <= `LQSB_USED_MASK; // see R07
        ntr_r[`LQSB_GRP_UPP] <= '0;
      end
    end
  end

  // query answer and summary outputs, all registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
      oper_low_sum <= 1'b0;
      oper_upp_sum <= 1'b0;
    end else if (clk_en) begin
      rsp.valid <= q_rd;
      rsp.data <= q_rd ? rd_mux : '0; // see R19
      oper_low_sum <= |(event_r[`LQSB_GRP_LOW] & enab_r[`LQSB_GRP_LOW]); // see R16
      oper_upp_sum <= |(event_r[`LQSB_GRP_UPP] & enab_r[`LQSB_GRP_UPP]); // see R17
    end
  end

  // checks
  sequence rd_event_s;
    clk_en && q_rd && req.part == `LQSB_PART_EVENT;
  endsequence

  bit15_zero_a: assert property (@(posedge clock) disable iff (!rstn) // see R09
    !rsp.data[15]) else $error("bit 15 set in answer");
  unused_bits_a: assert property (@(posedge clock) disable iff (!rstn) // see R04
    (cond_r[0] & ~`LQSB_USED_MASK) == '0) else $error("unused lower bit set");
  answer_lat_a: assert property (@(posedge clock) disable iff (!rstn) // see R19
    clk_en && q_rd |=> rsp.valid) else $error("no answer after query");
  answer_val_a: assert property (@(posedge clock) disable iff (!rstn) // see R19
    clk_en && q_rd |=> rsp.data == $past(rd_mux)) else $error("answer mismatch");
  low_cond_a: assert property (@(posedge clock) disable iff (!rstn) // see R01
    clk_en |=> cond_r[0][8:1] == $past(win_below_low)) else $error("lower condition wrong");
  upp_cond_a: assert property (@(posedge clock) disable iff (!rstn) // see R05
    clk_en |=> cond_r[1][8:1] == $past(win_above_upp)) else $error("upper condition wrong");
  ev_rise_a: assert property (@(posedge clock) disable iff (!rstn) // see R21
    clk_en && (rise[0] & ptr_r[0]) != '0 |=> (event_r[0] & $past(rise[0] & ptr_r[0])) != '0)
    else $error("rising event lost");
  ev_fall_a: assert property (@(posedge clock) disable iff (!rstn) // see R18
    clk_en && (fall[1] & ntr_r[1]) != '0 |=> (event_r[1] & $past(fall[1] & ntr_r[1])) != '0)
    else $error("falling event lost");
  rd_clear_a: assert property (@(posedge clock) disable iff (!rstn) // see R20
    rd_event_s and (g == 2'h2 && hit[2] == '0) |=> event_r[2] == '0) else $error("event not cleared");
  low_enable_a: assert property (@(posedge clock) disable iff (!rstn) // see R03
    clk_en && lower_limit_check_enable |=> ptr_r[0] == `LQSB_USED_MASK && ntr_r[0] == '0)
    else $error("lower check filters wrong");
  corrupt_set_a: assert property (@(posedge clock) disable iff (!rstn) // see R12
    clk_en && sens_hit[0] |=> ##1 cond_r[2][1]) else $error("corrupt bit not shown");
  win_set_a: assert property (@(posedge clock) disable iff (!rstn) // see R15
    clk_en && win_hit[0] |=> ##1 cond_r[3][1] || !clk_en) else $error("window bit not shown");
  sum_low_a: assert property (@(posedge clock) disable iff (!rstn) // see R16
    clk_en |=> oper_low_sum == |($past(event_r[0] & enab_r[0]))) else $error("summary wrong");
endmodule

/* verif/lqsb_host.sv */
// controller model that issues one-cycle status queries
// assumes the bank takes req at a rising edge and answers on rsp
module lqsb_host
  import lqsb_pkg::*;
(
  input wire logic clock,
  output lqsb_req_t req,
  input wire lqsb_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // strobe for one cycle, then wait a bounded time for the answer
  task automatic send(input int wr, input int g, input int p, input lqsb_word_t d,
                      output lqsb_word_t q, output logic ok);
    int n;
    ok = wr[0];
    q = '0;
    req <= '{1'b1, wr[0], g[1:0], p[2:0], d};
    @(posedge clock);
    req <= '0;
    if (ok) @(posedge clock); // writes give no answer
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clock);
      ok = (rsp.valid === 1'b1);
      q = rsp.data;
    end
  endtask
endmodule

/* verif/limit_and_questionable_status_bank_test.sv */
// self-checking bench for the limit and questionable status bank
// assumes lqsb_pkg compiled first and the host model beside it
module limit_and_questionable_status_bank_test
  import lqsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, low_en, upp_en, cen;
  logic [7:0] below, above, wev, wclr;
  logic [3:0] sev, sclr, stale;
  logic [63:0] scode;
  logic [127:0] wcode;
  lqsb_req_t req;
  lqsb_rsp_t rsp;
  logic low_sum, upp_sum;
  int err_total, compares;
  lqsb_bank dut (.clock(clock), .rstn(rstn), .clk_en(cen), .win_below_low(below),
    .win_above_upp(above), .lower_limit_check_enable(low_en), .upper_limit_check_enable(upp_en),
    .sens_err_valid(sev), .sens_err_code(scode), .sens_err_clear(sclr), .sens_zero_stale(stale),
    .win_err_valid(wev), .win_err_code(wcode), .win_err_clear(wclr), .req(req), .rsp(rsp),
    .oper_low_sum(low_sum), .oper_upp_sum(upp_sum));
  lqsb_host host (.clock(clock), .req(req), .rsp(rsp));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic print_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input lqsb_word_t seen, input lqsb_word_t exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // read one part and compare; a missing answer ends the run
  task automatic rd(input int g, input int p, input lqsb_word_t exp);
    lqsb_word_t q;
    logic ok;
    host.send(0, g, p, '0, q, ok);
    if (!ok) begin
      err_total++;
      print_verdict();
    end
    check(q, exp);
  endtask
  task automatic wr(input int g, input int p, input lqsb_word_t d);
    lqsb_word_t q;
    logic ok;
    host.send(1, g, p, d, q, ok);
  endtask
  // reset filters, unknown part, pattern of one word
  task automatic t_reset;
    for (int g = 0; g < 4; g++) begin
      rd(g, 2, 16'h01FE);
      rd(g, 3, 16'h0000);
      rd(g, 0, 16'h0000);
    end
    rd(0, 5, 16'h0000);
  endtask
  // lower group: windows 1 and 8, read clear, summary
  task automatic t_lower;
    below <= 8'h81;
    tick(3);
    rd(0, 0, 16'h0102);
    rd(0, 1, 16'h0102);
    rd(0, 1, 16'h0000);
    rd(0, 0, 16'h0102);
    wr(0, 4, 16'hFFFF);
    rd(0, 4, 16'h01FE);
    below <= 8'h80;
    tick(2);
    below <= 8'h81;
    tick(3);
    check({15'h0, low_sum}, 16'h0001);
    rd(0, 1, 16'h0002);
    tick(3);
    check({15'h0, low_sum}, 16'h0000);
  endtask
  // upper group: falling edge filter, then check enable
  task automatic t_upper;
    wr(1, 2, 16'h0000);
    wr(1, 3, 16'h0004);
    wr(1, 4, 16'h0080);
    above <= 8'h02;
    tick(3);
    rd(1, 0, 16'h0004);
    above <= 8'h00;
    tick(3);
    rd(1, 1, 16'h0004);
    upp_en <= 1'b1;
    low_en <= 1'b1;
    tick(3);
    rd(1, 2, 16'h01FE);
    rd(1, 3, 16'h0000);
    rd(0, 2, 16'h01FE);
    rd(0, 3, 16'h0000);
    above <= 8'h40;
    tick(3);
    check({15'h0, upp_sum}, 16'h0001);
    rd(1, 1, 16'h0080);
  endtask
  // frozen clock enable: a pulse on the lower inputs leaves no event
  task automatic t_freeze;
    cen <= 1'b0;
    below <= 8'h00;
    tick(3);
    below <= 8'h81;
    cen <= 1'b1;
    tick(2);
    rd(0, 1, 16'h0000);
    rd(0, 0, 16'h0102);
  endtask
  // power group: error codes per sensor and stale zeroing
  task automatic t_power;
    scode <= {16'hFF19, 16'h0000, 16'hFF18, 16'hFF1A};
    sev <= 4'hF;
    tick(1);
    sev <= 4'h0;
    stale <= 4'h5;
    tick(3);
    rd(2, 0, 16'h00B2);
    rd(2, 1, 16'h00B2);
    sclr <= 4'h9;
    tick(1);
    sclr <= 4'h0;
    stale <= 4'h0;
    tick(3);
    rd(2, 0, 16'h0000);
  endtask
  // window group: only the second error code counts
  task automatic t_window;
    wcode <= {16'hFF19, 48'h0, 16'hFF19, 32'h0, 16'hFF1A};
    wev <= 8'hFF;
    tick(1);
    wev <= 8'h00;
    tick(3);
    rd(3, 0, 16'h0110);
    wclr <= 8'h80;
    tick(1);
    wclr <= 8'h00;
    tick(3);
    rd(3, 0, 16'h0010);
    rd(3, 1, 16'h0110);
  endtask
  // main sequence
  initial begin
    {rstn, low_en, upp_en, below, above, wev, wclr, sev, sclr, stale} = '0;
    scode = '0;
    wcode = '0;
    cen = 1'b1;
    err_total = 0;
    compares = 0;
    tick(20);
    rstn <= 1'b1;
    tick(1);
    t_reset();
    t_lower();
    t_upper();
    t_freeze();
    t_power();
    t_window();
    print_verdict();
  end
endmodule
